/* File: spl_regs.vh */
// Register map, field positions, defaults and timing for the strap latch
// What this block does
// - Slave address is 010 followed by address straps three down to zero.
// - Floating address straps read one, giving default address 0101111.
// - Address straps captured only after power-up or reset, held until next.
// - Class-five strap floats low; low disables, high enables class five.
// - Class-five strap sampled after reset and held until the next reset.
// - Default-mode strap floats high for auto; low gives shutdown after reset.
// - Software may change the operating mode afterwards over the bus.
// - Default-mode strap latched after reset and picks the initial mode.
// - Cadence strap floats high enabling collision avoidance; low disables.
// - Cadence strap latched after reset; later pin changes are ignored.
// - Interrupt pin pulled low while an interrupt is pending, else released.
// - Run-enable low for the minimum time resets; release restores defaults.
// - Strap changes ignored in operation; sampled only at end of reset.
// - Writing the soft reset bit resets all registers and re-latches straps.
// - With cadence active, a failed detection waits two seconds before retry.
`ifndef SPL_REGS_VH
`define SPL_REGS_VH

`define SPL_OFF_STATUS 8'h00
`define SPL_OFF_MASK 8'h04
`define SPL_OFF_CTRL 8'h08
`define SPL_OFF_STRAPS 8'h0C

// Status and mask bit positions
`define SPL_EV_MATCH 0
`define SPL_EV_MISS 1
`define SPL_EV_FAIL 2
`define SPL_EV_RETRY 3
`define SPL_EV_W 4

// Control fields
`define SPL_CTRL_MODE_LO 0
`define SPL_CTRL_MODE_HI 1
`define SPL_CTRL_SOFT_RST 4

// Operating modes
`define SPL_MODE_SHUT 2'b00
`define SPL_MODE_MANUAL 2'b01
`define SPL_MODE_SEMI 2'b10
`define SPL_MODE_AUTO 2'b11

// Fixed upper address bits and floating strap levels
`define SPL_ADDR_HI 3'b010
`define SPL_ADDR_FLOAT 4'b1111
`define SPL_CL5_FLOAT 1'b0
`define SPL_AUTO_FLOAT 1'b1
`define SPL_MID_FLOAT 1'b1

// Timing: reset and retry figures and the clock
`define SPL_CLK_HZ 50000000
`define SPL_HWRST_US 100
`define SPL_RETRY_S 2
// Scaled in two steps so the product stays inside 32-bit integer range
`define SPL_HWRST_CYC ((`SPL_HWRST_US * (`SPL_CLK_HZ / 1000)) / 1000)
`define SPL_RETRY_CYC (`SPL_RETRY_S * `SPL_CLK_HZ)

`endif

/* File: spl_strap_latch.v */
// Strap latch, slave address former, reset sequencer and interrupt logic
`timescale 1ns/1ps
`include "spl_regs.vh"

module spl_strap_latch #(
  parameter [31:0] HWRST_CYC = `SPL_HWRST_CYC,
  parameter [31:0] RETRY_CYC = `SPL_RETRY_CYC
)
(
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Straps and run-enable
  input wire addr_pin_bit0_i,
  input wire addr_pin_bit1_i,
  input wire addr_pin_bit2_i,
  input wire addr_pin_bit3_i,
  input wire high_power_class_strap_i,
  input wire auto_mode_strap_i,
  input wire midspan_strap_i,
  input wire run_en_i,
  // Address compare from the serial front end
  input wire rx_addr_valid_i,
  input wire [6:0] rx_addr_i,
  output reg addr_ack_o,
  // Detection failure from the port sequencer
  input wire det_fail_i,
  output reg retry_hold_o,
  // Latched configuration and internal reset
  output reg [6:0] slave_addr_o,
  output reg class5_en_o,
  output reg midspan_en_o,
  output reg [1:0] mode_o,
  output wire int_reset_o,
  // Open-drain interrupt
  output wire int_n_o,
  output reg int_n_oe_o
);

  reg [6:0] strap_s1_q;
  reg [6:0] strap_s2_q;
  reg hw_rst_q;
  reg [31:0] low_cnt_q;
  reg soft_rst_q;
  reg rst_seen_q;
  reg ack_q;
  reg [`SPL_EV_W-1:0] status_q;
  reg [`SPL_EV_W-1:0] mask_q;
  reg [31:0] retry_cnt_q;
  wire int_rst;
  wire latch_now;
  wire wb_req;
  wire wr_ctrl;
  wire rd_status;
  wire [`SPL_EV_W-1:0] ev_set;
  wire retry_done;

  function sel_hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      sel_hit = (adr == off);
    end
  endfunction

  assign int_rst = rst_i | hw_rst_q | soft_rst_q;
  assign int_reset_o = int_rst;
  // First cycle after every kind of reset ends
  assign latch_now = rst_seen_q & ~int_rst;

  // Straps pass two flops before anyone looks at them
  always @(posedge clk_i)
  begin
    strap_s1_q <= {midspan_strap_i, auto_mode_strap_i,
                   high_power_class_strap_i, addr_pin_bit3_i,
                   addr_pin_bit2_i, addr_pin_bit1_i, addr_pin_bit0_i};
    strap_s2_q <= strap_s1_q;
  end

  // Run-enable low timer; only the external reset or run-enable high clears it, so the
  // hardware reset cannot cancel itself.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_cnt_q <= 32'h0000_0000;
      hw_rst_q <= 1'b0;
    end
    else if (run_en_i)
    begin
      low_cnt_q <= 32'h0000_0000;
      hw_rst_q <= 1'b0;
    end
    else
    begin
      if (low_cnt_q < HWRST_CYC)
        low_cnt_q <= low_cnt_q + 32'h0000_0001;
      if (low_cnt_q + 32'h0000_0001 >= HWRST_CYC)
        hw_rst_q <= 1'b1;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      rst_seen_q <= 1'b1;
    else
      rst_seen_q <= int_rst;
  end

  // Latched straps; reset values are the floating pin levels
  always @(posedge clk_i)
  begin
    if (int_rst)
    begin
      slave_addr_o <= {`SPL_ADDR_HI, `SPL_ADDR_FLOAT};
      class5_en_o <= `SPL_CL5_FLOAT;
      midspan_en_o <= `SPL_MID_FLOAT;
    end
    else if (latch_now)
    begin
      slave_addr_o <= {`SPL_ADDR_HI, strap_s2_q[3:0]};
      class5_en_o <= strap_s2_q[4];
      midspan_en_o <= strap_s2_q[6];
    end
  end

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_ack_o = ack_q;
  assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] &
                   sel_hit(wb_adr_i, `SPL_OFF_CTRL);
  assign rd_status = wb_req & ~wb_we_i &
                     sel_hit(wb_adr_i, `SPL_OFF_STATUS);

  // One wait state; unmapped addresses ack with zero data
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_req;
      if (wb_req & ~wb_we_i)
      begin
        case (wb_adr_i)
          `SPL_OFF_STATUS: wb_dat_o <= {28'h000_0000, status_q};
          `SPL_OFF_MASK: wb_dat_o <= {28'h000_0000, mask_q};
          `SPL_OFF_CTRL: wb_dat_o <= {30'h0000_0000, mode_o};
          `SPL_OFF_STRAPS: wb_dat_o <= {21'h00_0000, midspan_en_o,
                                        class5_en_o, 2'b00, slave_addr_o};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Mode and soft reset. The soft reset bit reads back zero.
  always @(posedge clk_i)
  begin
    if (rst_i)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= wr_ctrl & wb_dat_i[`SPL_CTRL_SOFT_RST];
  end

  always @(posedge clk_i)
  begin
    if (int_rst)
      mode_o <= `SPL_MODE_SHUT;
    else if (latch_now)
      mode_o <= strap_s2_q[5] ? `SPL_MODE_AUTO : `SPL_MODE_SHUT;
    else if (wr_ctrl & ~wb_dat_i[`SPL_CTRL_SOFT_RST])
      mode_o <= wb_dat_i[`SPL_CTRL_MODE_HI:`SPL_CTRL_MODE_LO];
  end

  always @(posedge clk_i)
  begin
    if (int_rst)
      mask_q <= {`SPL_EV_W{1'b0}};
    else if (wb_req & wb_we_i & wb_sel_i[0] &
             sel_hit(wb_adr_i, `SPL_OFF_MASK))
      mask_q <= wb_dat_i[`SPL_EV_W-1:0];
  end

  // Address compare
  always @(posedge clk_i)
  begin
    if (int_rst)
      addr_ack_o <= 1'b0;
    else
      addr_ack_o <= rx_addr_valid_i & (rx_addr_i == slave_addr_o);
  end

  // Cadence hold after failed detection; a new failure restarts the wait
  assign retry_done = retry_hold_o & (retry_cnt_q == 32'h0000_0001);
  always @(posedge clk_i)
  begin
    if (int_rst)
    begin
      retry_hold_o <= 1'b0;
      retry_cnt_q <= 32'h0000_0000;
    end
    else if (det_fail_i & midspan_en_o)
    begin
      retry_hold_o <= 1'b1;
      retry_cnt_q <= RETRY_CYC;
    end
    else if (retry_hold_o)
    begin
      retry_cnt_q <= retry_cnt_q - 32'h0000_0001;
      if (retry_done)
        retry_hold_o <= 1'b0;
    end
  end

  assign ev_set[`SPL_EV_MATCH] = rx_addr_valid_i & (rx_addr_i == slave_addr_o);
  assign ev_set[`SPL_EV_MISS] = rx_addr_valid_i & (rx_addr_i != slave_addr_o);
  assign ev_set[`SPL_EV_FAIL] = det_fail_i;
  assign ev_set[`SPL_EV_RETRY] = retry_done;

  // Clear on read; an event in the same cycle survives
  always @(posedge clk_i)
  begin
    if (int_rst)
      status_q <= {`SPL_EV_W{1'b0}};
    else
      status_q <= (rd_status ? {`SPL_EV_W{1'b0}} : status_q) | ev_set;
  end

  assign int_n_o = 1'b0;
  always @(posedge clk_i)
  begin
    if (int_rst)
      int_n_oe_o <= 1'b0;
    else
      int_n_oe_o <= |(status_q & mask_q);
  end

endmodule // spl_strap_latch

/* File: spl_strap_checker_properties.sv */
// Port assertions for the strap latch
`timescale 1ns/1ps
module spl_strap_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire rx_addr_valid_i,
  input wire [6:0] rx_addr_i,
  input wire addr_ack_o,
  input wire [6:0] slave_addr_o,
  input wire class5_en_o,
  input wire midspan_en_o,
  input wire [1:0] mode_o,
  input wire det_fail_i,
  input wire retry_hold_o,
  input wire int_reset_o,
  input wire int_n_o,
  input wire int_n_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence hit;
    !int_reset_o && rx_addr_valid_i && rx_addr_i == slave_addr_o;
  endsequence
  ack_timing_a: assert property (wb_req |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  addr_hit_a: assert property (hit |=> addr_ack_o)
    else $error("matching address not acknowledged");
  addr_miss_a: assert property (rx_addr_valid_i &&
    rx_addr_i != slave_addr_o |=> !addr_ack_o)
    else $error("foreign address acknowledged");
  addr_form_a: assert property (slave_addr_o[6:4] == 3'h2)
    else $error("upper address bits wrong");
  strap_hold_a: assert property (!int_reset_o [*4] |->
    $stable({slave_addr_o, class5_en_o, midspan_en_o}))
    else $error("latched straps moved outside reset");
  retry_start_a: assert property (!int_reset_o && det_fail_i &&
    midspan_en_o
    |=> retry_hold_o)
    else $error("retry hold not started");
  retry_off_a: assert property (!midspan_en_o &&
    !retry_hold_o |=> !retry_hold_o)
    else $error("retry hold without cadence");
  reset_mode_a: assert property (int_reset_o |=>
    mode_o == 2'h0)
    else $error("mode not cleared in reset");
  int_od_a: assert property (int_n_o == 1'b0)
    else $error("open-drain data not low");
  int_clear_a: assert property (int_reset_o |=> !int_n_oe_o)
    else $error("interrupt pin still pulled during reset");
endmodule // spl_strap_checker
bind spl_strap_latch spl_strap_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rx_addr_valid_i(rx_addr_valid_i), .rx_addr_i(rx_addr_i),
  .addr_ack_o(addr_ack_o), .slave_addr_o(slave_addr_o),
  .class5_en_o(class5_en_o), .midspan_en_o(midspan_en_o),
  .mode_o(mode_o), .det_fail_i(det_fail_i), .retry_hold_o(retry_hold_o),
  .int_reset_o(int_reset_o), .int_n_o(int_n_o),
  .int_n_oe_o(int_n_oe_o));

/* File: spl_host_model.sv */
// Host model presenting received serial addresses
`timescale 1ns/1ps
module spl_host_model (
  input wire clk_i,
  input wire go_i,
  input wire [6:0] addr_i,
  output reg valid_o,
  output reg [6:0] addr_o
);
  initial valid_o = 1'b0;
  initial addr_o = 7'h0;
  // Idle address toggles so a stale value cannot match by luck
  always @(posedge clk_i)
  begin
    valid_o <= go_i;
    addr_o <= go_i ? addr_i : ~addr_o;
  end
endmodule // spl_host_model

/* File: spl_strap_latch_test.sv */
// Self-checking bench for the strap latch
`timescale 1ns/1ps
module spl_strap_latch_test;
  reg clk_i = 0;
  reg rst_i = 1;
  reg cyc = 0, we = 0, df = 0, go = 0, cl5 = 0, au = 1, mid = 1;
  reg run_en = 1;
  reg [7:0] adr = 8'h0;
  reg [31:0] wd = 32'h0, rd;
  reg [3:0] ap = 4'hf;
  reg [6:0] ta = 7'h0;
  wire [31:0] dat;
  wire [6:0] sa, ra;
  wire [1:0] mode;
  wire ack, aack, hold, c5, md, v, oe;
  integer n_fail = 0, total_checks = 0, ncyc = 0, k;
  spl_host_model host (.clk_i(clk_i), .go_i(go), .addr_i(ta),
    .valid_o(v), .addr_o(ra));
  spl_strap_latch #(.HWRST_CYC(32'h8), .RETRY_CYC(32'h10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd),
    .wb_dat_o(dat), .wb_ack_o(ack), .addr_pin_bit0_i(ap[0]),
    .addr_pin_bit1_i(ap[1]), .addr_pin_bit2_i(ap[2]),
    .addr_pin_bit3_i(ap[3]), .high_power_class_strap_i(cl5),
    .auto_mode_strap_i(au), .midspan_strap_i(mid), .run_en_i(run_en),
    .rx_addr_valid_i(v), .rx_addr_i(ra), .addr_ack_o(aack),
    .det_fail_i(df), .retry_hold_o(hold), .slave_addr_o(sa),
    .class5_en_o(c5), .midspan_en_o(md), .mode_o(mode),
    .int_reset_o(), .int_n_o(), .int_n_oe_o(oe));
  initial forever #10 clk_i = ~clk_i;
  task summarize;
  begin
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end
  endtask
  always @(posedge clk_i)
  begin
    ncyc++;
    if (ncyc > 3000)
    begin
      n_fail++;
      summarize;
    end
  end
  task chk(input [31:0] g, input [31:0] e, input string nm);
  begin
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // Values read right after an edge are the ones sampled at it
  task bus(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    cyc <= 0;
    we <= 0;
  end
  endtask
  task send(input [6:0] a, input e);
  begin
    @(posedge clk_i);
    go <= 1;
    ta <= a;
    @(posedge clk_i);
    go <= 0;
    repeat (2) @(posedge clk_i);
    chk(aack, e, "addr_ack");
  end
  endtask
  task t_defaults;
  begin
    chk({sa, c5, md, mode}, 11'h2f7, "cfg");
    bus(0, 8'h0c, 32'h0);
    chk(rd, 32'h42f, "straps");
    bus(0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped");
  end
  endtask
  task t_irq;
  begin
    bus(1, 8'h04, 32'h1);
    send(7'h2f, 1'b1);
    send(7'h2e, 1'b0);
    chk(oe, 1'b1, "irq");
    bus(0, 8'h00, 32'h0);
    chk(rd, 32'h3, "status");
    repeat (2) @(posedge clk_i);
    chk(oe, 1'b0, "irq_clr");
    send(7'h2e, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(oe, 1'b0, "masked");
  end
  endtask
  task t_retry(input [31:0] e);
  begin
    @(posedge clk_i);
    df <= 1;
    @(posedge clk_i);
    df <= 0;
    k = 0;
    repeat (20)
    begin
      @(posedge clk_i);
      if (hold === 1'b1) k++;
    end
    chk(k, e, "hold_len");
    bus(0, 8'h00, 32'h0);
    chk(rd[3], e != 0, "retry_ev");
    chk(rd[2], 1'b1, "fail_ev");
  end
  endtask
  task t_soft;
  begin
    ap <= 4'h5;
    au <= 0;
    mid <= 0;
    cl5 <= 1;
    repeat (4) @(posedge clk_i);
    chk(sa, 7'h2f, "addr_held");
    bus(1, 8'h08, 32'h10);
    repeat (6) @(posedge clk_i);
    chk({sa, c5, md, mode}, 11'h258, "cfg");
    bus(1, 8'h08, 32'h2);
    @(posedge clk_i);
    chk(mode, 2'h2, "mode");
    bus(0, 8'h08, 32'h0);
    chk(rd, 32'h2, "mode_rd");
  end
  endtask
  task t_hw(input [7:0] n, input [10:0] e);
  begin
    ap <= 4'hf;
    au <= 1;
    mid <= 1;
    cl5 <= 0;
    run_en <= 0;
    repeat (n) @(posedge clk_i);
    run_en <= 1;
    repeat (6) @(posedge clk_i);
    chk({sa, c5, md, mode}, e, "hw_reset");
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    repeat (3) @(posedge clk_i);
    t_defaults;
    t_irq;
    t_retry(32'h10);
    t_soft;
    t_retry(32'h0);
    t_hw(8'h07, 11'h25a);
    t_hw(8'h08, 11'h2f7);
    summarize;
  end
endmodule // spl_strap_latch_test
